// *** rtl/tlbt_task_link.sv ***
// Task switch sequencer keeping busy bits, nesting flag and link field.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Every completed switch sets the task-switched flag in control word zero.
// - Call or interrupt writes old selector into new link, then sets nesting.
// - Interrupt return switches to the linked task only when nesting is set.
// - Jump never nests; link unused, nesting flag taken from new record.
// - Jump, call and interrupt set new busy bit; return needs it already set.
// - Old busy bit cleared on jump and return, kept on call and interrupt.
// - New nesting flag from record on jump or return, forced on call or interrupt.
// - Old saved nesting flag cleared only by an interrupt return.
// - New link written only on call or interrupt; old link never.
// - Call or interrupt to a busy task raises general protection fault.
// - Every busy bit update is a locked read-modify-write.
// - Fault error code carries the index of the offending descriptor.
// - Selector valid only in right table, within limit, right type.
// - Page directory base loads from the new record on each switch.
// - Four fault kinds: absent, protection, invalid record, stack.
// - Nesting flag writable by software without any privilege check.
module tlbt_task_link #(
  parameter logic [19:0] MinRecLimit = tlbt_pkg::REC_MIN_LIMIT
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic [tlbt_pkg::REG_AW-1:0] regAddr,
  input  wire logic [31:0]                regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [31:0]                regRdata,
  output logic                            memReq,
  output logic                            memWe,
  output logic                            memLock,
  output logic      [31:0]                memAddr,
  output logic      [31:0]                memWdata,
  input  wire logic                       memAck,
  input  wire logic [31:0]                memRdata,
  output logic                            switchActive
);
  import tlbt_pkg::*;

  if (MinRecLimit < REC_FLAGS_OFS[19:0] + 20'h00003) begin : gBadLimit
    $error("Least record limit leaves no room for the flags word.");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_LINK_RD, S_SEL_CHK, S_DLO_RD, S_DHI_RD, S_DESC_CHK,
    S_OLD_LRD, S_OLD_LWR, S_FLG_WR, S_NEW_FLG_RD, S_PDB_RD,
    S_LINK_WR, S_NEW_LRD, S_NEW_LWR, S_COMMIT, S_FAULT
  } tlbt_state_e;

  tlbt_state_e state_q, state_d;
  tlbt_kind_e  kind_q, kind_d;
  tlbt_fault_e fault_q, fault_d;
  logic [15:0] newSel_q, newSel_d, taskSel_q, taskSel_d;
  logic [15:0] tableLimit_q, tableLimit_d, errCode_q, errCode_d;
  logic [31:0] descLo_q, descLo_d, descHi_q, descHi_d;
  logic [31:0] newBase_q, newBase_d, newFlags_q, newFlags_d;
  logic [31:0] newPdb_q, newPdb_d, rmw_q, rmw_d;
  logic [31:0] tableBase_q, tableBase_d, taskBase_q, taskBase_d;
  logic [31:0] flags_q, flags_d, ctrl0_q, ctrl0_d, pdb_q, pdb_d;
  logic [31:0] memAddr_q, memAddr_d, memWdata_q, memWdata_d;
  logic [31:0] rdata_q, rdata_d;
  logic        memReq_q, memReq_d, memWe_q, memWe_d;
  logic        memLock_q, memLock_d;
  logic        done_q, done_d, noSwitch_q, noSwitch_d;
  logic        nestKind, cmdWr;
  tlbt_kind_e  cmdKind;

  tlbt_sel_if chkIf ();

  tlbt_sel_check #(
    .MinRecLimit (MinRecLimit)
  ) uCheck (
    .chk (chkIf.judge)
  );

  // Byte address of the descriptor that a selector names.
  function automatic logic [31:0] descAddr(input logic [31:0] base,
                                           input logic [15:0] sel);
    descAddr = base + {16'h0000, sel[15:3], 3'h0};
  endfunction

  // States that hold a memory request, and those inside a locked update.
  function automatic logic isMem(input tlbt_state_e st);
    isMem = !(st inside {S_IDLE, S_SEL_CHK, S_DESC_CHK, S_COMMIT,
                         S_FAULT});
  endfunction

  function automatic logic isLocked(input tlbt_state_e st);
    isLocked = st inside {S_OLD_LRD, S_OLD_LWR, S_NEW_LRD, S_NEW_LWR};
  endfunction

  // Checker inputs come straight from the captured selector and words.
  assign chkIf.sel        = newSel_q;
  assign chkIf.tableLimit = tableLimit_q;
  assign chkIf.descLo     = descLo_q;
  assign chkIf.descHi     = descHi_q;
  assign chkIf.isIret     = (kind_q == KIND_INTERRUPT_RETURN);

  assign nestKind = (kind_q == KIND_CALL) || (kind_q == KIND_INTR);
  assign cmdWr    = regWr && (regAddr == REG_CMD_OFS);
  assign cmdKind  = tlbt_kind_e'(regWdata[CMD_KIND_LSB +: 2]);

  // Sequencer, software registers and memory request next values.
  always_comb begin
    state_d      = state_q;
    kind_d       = kind_q;
    fault_d      = fault_q;
    newSel_d     = newSel_q;
    taskSel_d    = taskSel_q;
    tableLimit_d = tableLimit_q;
    errCode_d    = errCode_q;
    descLo_d     = descLo_q;
    descHi_d     = descHi_q;
    newBase_d    = newBase_q;
    newFlags_d   = newFlags_q;
    newPdb_d     = newPdb_q;
    rmw_d        = rmw_q;
    tableBase_d  = tableBase_q;
    taskBase_d   = taskBase_q;
    flags_d      = flags_q;
    ctrl0_d      = ctrl0_q;
    pdb_d        = pdb_q;
    done_d       = done_q;
    noSwitch_d   = noSwitch_q;
    memAddr_d    = memAddr_q;
    memWdata_d   = memWdata_q;
    // Software writes; a flags write needs no privilege at all.
    if (regWr) begin
      unique case (regAddr)
        REG_TBASE_OFS:  tableBase_d  = regWdata;
        REG_TLIMIT_OFS: tableLimit_d = regWdata[15:0];
        REG_TSEL_OFS:   taskSel_d    = regWdata[15:0];
        REG_TRBASE_OFS: taskBase_d   = regWdata;
        REG_FLAGS_OFS:  flags_d      = regWdata;
        REG_CTRL0_OFS:  ctrl0_d      = regWdata;
        default: ;
      endcase
    end
    unique case (state_q)
      S_IDLE: begin
        if (cmdWr) begin
          kind_d     = cmdKind;
          fault_d    = FLT_NONE;
          done_d     = 1'b0;
          noSwitch_d = 1'b0;
          newSel_d   = regWdata[CMD_SEL_LSB +: 16];
          if (cmdKind != KIND_INTERRUPT_RETURN) begin
            state_d = S_SEL_CHK;
          end else if (flags_q[FLAGS_NT_BIT]) begin
            state_d = S_LINK_RD;
          end else begin
            noSwitch_d = 1'b1;
            done_d     = 1'b1;
          end
        end
      end
      S_LINK_RD: if (memAck) begin
        newSel_d = memRdata[15:0];
        state_d  = S_SEL_CHK;
      end
      S_SEL_CHK: begin
        if (chkIf.selOk) begin
          state_d = S_DLO_RD;
        end else begin
          fault_d   = (kind_q == KIND_INTERRUPT_RETURN) ? FLT_INV_TASK : FLT_GEN_PROT;
          errCode_d = {chkIf.errIndex, 3'h0};
          state_d   = S_FAULT;
        end
      end
      S_DLO_RD: if (memAck) begin
        descLo_d = memRdata;
        state_d  = S_DHI_RD;
      end
      S_DHI_RD: if (memAck) begin
        descHi_d = memRdata;
        state_d  = S_DESC_CHK;
      end
      S_DESC_CHK: begin
        newBase_d = {descHi_q[31:24], descHi_q[7:0], descLo_q[31:16]};
        if (chkIf.fault != FLT_NONE) begin
          fault_d   = chkIf.fault;
          errCode_d = {chkIf.errIndex, 3'h0};
          state_d   = S_FAULT;
        end else if (nestKind) begin
          state_d = S_FLG_WR;
        end else begin
          state_d = S_OLD_LRD;
        end
      end
      S_OLD_LRD: if (memAck) begin
        rmw_d   = memRdata;
        state_d = S_OLD_LWR;
      end
      S_OLD_LWR: if (memAck) state_d = S_FLG_WR;
      S_FLG_WR: if (memAck) state_d = S_NEW_FLG_RD;
      S_NEW_FLG_RD: if (memAck) begin
        newFlags_d = memRdata;
        state_d    = S_PDB_RD;
      end
      S_PDB_RD: if (memAck) begin
        newPdb_d = memRdata;
        if (nestKind) begin
          state_d = S_LINK_WR;
        end else if (kind_q == KIND_INTERRUPT_RETURN) begin
          state_d = S_COMMIT;
        end else begin
          state_d = S_NEW_LRD;
        end
      end
      S_LINK_WR: if (memAck) state_d = S_NEW_LRD;
      S_NEW_LRD: if (memAck) begin
        rmw_d   = memRdata;
        state_d = S_NEW_LWR;
      end
      S_NEW_LWR: if (memAck) state_d = S_COMMIT;
      S_COMMIT: begin
        // The switch overrides a software write in the same cycle.
        taskSel_d  = newSel_q;
        taskBase_d = newBase_q;
        pdb_d      = newPdb_q;
        flags_d    = newFlags_q;
        if (nestKind) begin
          flags_d[FLAGS_NT_BIT] = 1'b1;
        end
        ctrl0_d[CTRL0_TS_BIT] = 1'b1;
        done_d  = 1'b1;
        state_d = S_IDLE;
      end
      S_FAULT: begin
        done_d  = 1'b1;
        state_d = S_IDLE;
      end
    endcase
    // Address and data for the request of the state being entered.
    memReq_d  = isMem(state_d);
    memWe_d   = state_d inside {S_OLD_LWR, S_NEW_LWR, S_FLG_WR, S_LINK_WR};
    memLock_d = isLocked(state_d);
    unique case (state_d)
      S_LINK_RD:    memAddr_d = taskBase_q + REC_LINK_OFS;
      S_DLO_RD:     memAddr_d = descAddr(tableBase_q, newSel_d);
      S_DHI_RD:     memAddr_d = descAddr(tableBase_q, newSel_d) + DESC_HI_OFS;
      S_OLD_LRD:    memAddr_d = descAddr(tableBase_q, taskSel_q) + DESC_HI_OFS;
      S_OLD_LWR: begin
        memWdata_d                = rmw_d;
        memWdata_d[DESC_BUSY_BIT] = 1'b0;
      end
      S_FLG_WR: begin
        memAddr_d  = taskBase_q + REC_FLAGS_OFS;
        memWdata_d = flags_q;
        if (kind_q == KIND_INTERRUPT_RETURN) begin
          memWdata_d[FLAGS_NT_BIT] = 1'b0;
        end
      end
      S_NEW_FLG_RD: memAddr_d = newBase_q + REC_FLAGS_OFS;
      S_PDB_RD:     memAddr_d = newBase_q + REC_PDB_OFS;
      S_LINK_WR: begin
        memAddr_d  = newBase_q + REC_LINK_OFS;
        memWdata_d = {16'h0000, taskSel_q};
      end
      S_NEW_LRD:    memAddr_d = descAddr(tableBase_q, newSel_q) + DESC_HI_OFS;
      S_NEW_LWR: begin
        memWdata_d                = rmw_d;
        memWdata_d[DESC_BUSY_BIT] = 1'b1;
      end
      default: ;
    endcase
  end

  // Register stage of the sequencer group.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= S_IDLE;
      kind_q       <= KIND_JUMP;
      fault_q      <= FLT_NONE;
      newSel_q     <= HALF_RST;
      taskSel_q    <= HALF_RST;
      tableLimit_q <= HALF_RST;
      errCode_q    <= HALF_RST;
      descLo_q     <= WORD_RST;
      descHi_q     <= WORD_RST;
      newBase_q    <= WORD_RST;
      newFlags_q   <= WORD_RST;
      newPdb_q     <= WORD_RST;
      rmw_q        <= WORD_RST;
      tableBase_q  <= WORD_RST;
      taskBase_q   <= WORD_RST;
      flags_q      <= FLAGS_RST;
      ctrl0_q      <= CTRL0_RST;
      pdb_q        <= WORD_RST;
      done_q       <= 1'b0;
      noSwitch_q   <= 1'b0;
      memAddr_q    <= WORD_RST;
      memWdata_q   <= WORD_RST;
      memReq_q     <= 1'b0;
      memWe_q      <= 1'b0;
      memLock_q    <= 1'b0;
    end else begin
      state_q      <= state_d;
      kind_q       <= kind_d;
      fault_q      <= fault_d;
      newSel_q     <= newSel_d;
      taskSel_q    <= taskSel_d;
      tableLimit_q <= tableLimit_d;
      errCode_q    <= errCode_d;
      descLo_q     <= descLo_d;
      descHi_q     <= descHi_d;
      newBase_q    <= newBase_d;
      newFlags_q   <= newFlags_d;
      newPdb_q     <= newPdb_d;
      rmw_q        <= rmw_d;
      tableBase_q  <= tableBase_d;
      taskBase_q   <= taskBase_d;
      flags_q      <= flags_d;
      ctrl0_q      <= ctrl0_d;
      pdb_q        <= pdb_d;
      done_q       <= done_d;
      noSwitch_q   <= noSwitch_d;
      memAddr_q    <= memAddr_d;
      memWdata_q   <= memWdata_d;
      memReq_q     <= memReq_d;
      memWe_q      <= memWe_d;
      memLock_q    <= memLock_d;
    end
  end

  // Read data for the cycle after a read strobe; zero otherwise.
  always_comb begin
    rdata_d = WORD_RST;
    if (regRd) begin
      unique case (regAddr)
        REG_CMD_OFS: begin
          rdata_d[STS_FAULT_LSB +: 3] = fault_q;
          rdata_d[STS_ACTIVE_BIT]     = (state_q != S_IDLE);
          rdata_d[STS_DONE_BIT]       = done_q;
          rdata_d[STS_NOSW_BIT]       = noSwitch_q;
        end
        REG_TBASE_OFS:  rdata_d = tableBase_q;
        REG_TLIMIT_OFS: rdata_d = {16'h0000, tableLimit_q};
        REG_TSEL_OFS:   rdata_d = {16'h0000, taskSel_q};
        REG_TRBASE_OFS: rdata_d = taskBase_q;
        REG_FLAGS_OFS:  rdata_d = flags_q;
        REG_CTRL0_OFS:  rdata_d = ctrl0_q;
        REG_PDB_OFS:    rdata_d = pdb_q;
        REG_ERR_OFS:    rdata_d = {16'h0000, errCode_q};
        default:        rdata_d = WORD_RST;
      endcase
    end
  end

  // Register stage of the read data.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= WORD_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign regRdata     = rdata_q;
  assign memReq       = memReq_q;
  assign memWe        = memWe_q;
  assign memLock      = memLock_q;
  assign memAddr      = memAddr_q;
  assign memWdata     = memWdata_q;
  assign switchActive = (state_q != S_IDLE);

  // Checks on the switch sequence.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence sNewBusySet;
    ##1 (state_q == S_NEW_LWR && memLock && memWe &&
         memWdata[DESC_BUSY_BIT]);
  endsequence

  sequence sOldBusyClr;
    ##1 (state_q == S_OLD_LWR && memLock && memWe &&
         !memWdata[DESC_BUSY_BIT]);
  endsequence

  AST_TS_SET: assert property (
    state_q == S_COMMIT |=> ctrl0_q[CTRL0_TS_BIT] && done_q)
    else $error("Task-switched flag not set after a switch.");

  AST_NT_NEST: assert property (
    state_q == S_COMMIT && nestKind |=> flags_q[FLAGS_NT_BIT])
    else $error("Nesting flag not forced on a nesting switch.");

  AST_NT_JUMP: assert property (
    state_q == S_COMMIT && kind_q == KIND_JUMP
    |=> flags_q[FLAGS_NT_BIT] == $past(newFlags_q[FLAGS_NT_BIT]))
    else $error("Jump switch did not take the record nesting flag.");

  AST_INTERRUPT_RETURN_FLAT: assert property (
    state_q == S_IDLE && cmdWr && cmdKind == KIND_INTERRUPT_RETURN &&
    !flags_q[FLAGS_NT_BIT] |=> state_q == S_IDLE && noSwitch_q)
    else $error("Return without nesting started a switch.");

  AST_INTERRUPT_RETURN_LINK: assert property (
    state_q == S_IDLE && cmdWr && cmdKind == KIND_INTERRUPT_RETURN &&
    flags_q[FLAGS_NT_BIT]
    |=> state_q == S_LINK_RD && memReq && !memWe &&
        memAddr == taskBase_q + REC_LINK_OFS)
    else $error("Nested return did not fetch the link field.");

  AST_BUSY_GP: assert property (
    state_q == S_DESC_CHK && nestKind && chkIf.selOk &&
    descHi_q[DESC_P_BIT] && descHi_q[DESC_BUSY_BIT] &&
    ((descHi_q[11:8] & DESC_TYPE_MASK) == DESC_TYPE_REC)
    |=> state_q == S_FAULT && fault_q == FLT_GEN_PROT)
    else $error("Nesting switch to a busy task did not fault.");

  AST_NEW_RMW: assert property (
    state_q == S_NEW_LRD && memAck |-> sNewBusySet)
    else $error("Incoming busy bit not set under lock.");

  AST_OLD_RMW: assert property (
    state_q == S_OLD_LRD && memAck |-> sOldBusyClr)
    else $error("Outgoing busy bit not cleared under lock.");

  AST_LOCK_HELD: assert property (
    memReq && memWe && memAddr == descAddr(tableBase_q, newSel_q) +
    DESC_HI_OFS && state_q != S_IDLE |-> memLock)
    else $error("Descriptor write left unlocked.");

  AST_LINK_WR: assert property (
    state_q == S_LINK_WR |-> nestKind && memWe &&
    memWdata == {16'h0000, taskSel_q} && memAddr != taskBase_q)
    else $error("Link field written on the wrong switch or task.");

  AST_OLD_NT: assert property (
    state_q == S_FLG_WR && memReq |-> memWdata[FLAGS_NT_BIT] ==
    (kind_q != KIND_INTERRUPT_RETURN && flags_q[FLAGS_NT_BIT]))
    else $error("Saved nesting flag of the old task is wrong.");

  AST_PDB: assert property (
    state_q == S_COMMIT |=> pdb_q == $past(newPdb_q))
    else $error("Page directory base not loaded on switch.");

  AST_ERRCODE: assert property (
    state_q == S_DESC_CHK && chkIf.fault != FLT_NONE
    |=> state_q == S_FAULT && errCode_q[15:3] == $past(newSel_q[15:3]))
    else $error("Error code does not hold the failing index.");

endmodule
`default_nettype wire

// *** rtl/tlbt_pkg.sv ***
// Shared constants and types of the task linkage and busy tracking block.
package tlbt_pkg;

  // Register offsets on the software port (byte addresses).
  localparam int          REG_AW          = 6;
  localparam logic [5:0]  REG_CMD_OFS     = 6'h00;
  localparam logic [5:0]  REG_TBASE_OFS   = 6'h04;
  localparam logic [5:0]  REG_TLIMIT_OFS  = 6'h08;
  localparam logic [5:0]  REG_TSEL_OFS    = 6'h0C;
  localparam logic [5:0]  REG_TRBASE_OFS  = 6'h10;
  localparam logic [5:0]  REG_FLAGS_OFS   = 6'h14;
  localparam logic [5:0]  REG_CTRL0_OFS   = 6'h18;
  localparam logic [5:0]  REG_PDB_OFS     = 6'h1C;
  localparam logic [5:0]  REG_ERR_OFS     = 6'h20;

  // Command word fields.
  localparam int          CMD_KIND_LSB    = 0;
  localparam int          CMD_SEL_LSB     = 16;

  // Status word fields, read at the command offset.
  localparam int          STS_FAULT_LSB   = 0;
  localparam int          STS_ACTIVE_BIT  = 4;
  localparam int          STS_DONE_BIT    = 5;
  localparam int          STS_NOSW_BIT    = 6;

  // Flag positions in the processor flags word and control word zero.
  localparam int          FLAGS_NT_BIT    = 14;
  localparam int          CTRL0_TS_BIT    = 3;
  localparam logic [31:0] FLAGS_RST       = 32'h0000_0002;
  localparam logic [31:0] CTRL0_RST       = 32'h0000_0000;
  localparam logic [31:0] WORD_RST        = 32'h0000_0000;
  localparam logic [15:0] HALF_RST        = 16'h0000;

  // Task-state record layout (byte offsets from the record base).
  localparam logic [31:0] REC_LINK_OFS    = 32'h0000_0000;
  localparam logic [31:0] REC_PDB_OFS     = 32'h0000_001C;
  localparam logic [31:0] REC_FLAGS_OFS   = 32'h0000_0024;
  localparam logic [19:0] REC_MIN_LIMIT   = 20'h00067;

  // Descriptor layout: high word offset and bit positions in it.
  localparam logic [31:0] DESC_HI_OFS     = 32'h0000_0004;
  localparam int          DESC_BUSY_BIT   = 9;
  localparam int          DESC_P_BIT      = 15;
  localparam logic [3:0]  DESC_TYPE_MASK  = 4'hD;
  localparam logic [3:0]  DESC_TYPE_REC   = 4'h9;

  // Selector fields.
  localparam int          SEL_TI_BIT      = 2;

  // Kind of transfer that starts a switch; software writes these codes.
  typedef enum logic [1:0] {
    KIND_JUMP = 2'h0,
    KIND_CALL = 2'h1,
    KIND_INTR = 2'h2,
    KIND_INTERRUPT_RETURN = 2'h3
  } tlbt_kind_e;

  // Fault kinds reported for a failed switch.
  typedef enum logic [2:0] {
    FLT_NONE       = 3'h0,
    FLT_SEG_ABSENT = 3'h1,
    FLT_GEN_PROT   = 3'h2,
    FLT_INV_TASK   = 3'h3,
    FLT_STACK      = 3'h4
  } tlbt_fault_e;

endpackage

// *** rtl/tlbt_sel_if.sv ***
// Interface between the switch sequencer and the selector checker.
`timescale 1ns/1ns
`default_nettype none
interface tlbt_sel_if;
  import tlbt_pkg::*;
  logic [15:0] sel;
  logic [15:0] tableLimit;
  logic [31:0] descLo;
  logic [31:0] descHi;
  logic        isIret;
  logic        selOk;
  tlbt_fault_e fault;
  logic [12:0] errIndex;
  modport judge (input sel, tableLimit, descLo, descHi, isIret,
                 output selOk, fault, errIndex);
  modport user (output sel, tableLimit, descLo, descHi, isIret,
                input selOk, fault, errIndex);
endinterface
`default_nettype wire

// *** rtl/tlbt_sel_check.sv ***
// Selector and descriptor checker for the incoming task-state record.
`timescale 1ns/1ns
`default_nettype none
module tlbt_sel_check #(
  parameter logic [19:0] MinRecLimit = tlbt_pkg::REC_MIN_LIMIT
) (
  tlbt_sel_if.judge chk
);
  import tlbt_pkg::*;

  logic [12:0] idx;
  logic [3:0]  typ;
  logic [19:0] limit;
  logic        busy;

  // Checks run in fixed priority; the first failing one names the fault.
  always_comb begin
    idx          = chk.sel[15:3];
    typ          = chk.descHi[11:8];
    busy         = chk.descHi[DESC_BUSY_BIT];
    limit        = {chk.descHi[19:16], chk.descLo[15:0]};
    chk.errIndex = idx;
    // Global table only, and the whole descriptor inside the limit.
    chk.selOk    = !chk.sel[SEL_TI_BIT] &&
                   ({idx, 3'h7} <= chk.tableLimit);
    if (!chk.selOk || ((typ & DESC_TYPE_MASK) != DESC_TYPE_REC)) begin
      chk.fault = chk.isIret ? FLT_INV_TASK : FLT_GEN_PROT;
    end else if (!chk.descHi[DESC_P_BIT]) begin
      chk.fault = FLT_SEG_ABSENT;
    end else if (!chk.isIret && busy) begin
      chk.fault = FLT_GEN_PROT;
    end else if (chk.isIret && !busy) begin
      chk.fault = FLT_INV_TASK;
    end else if (limit < MinRecLimit) begin
      chk.fault = FLT_INV_TASK;
    end else begin
      chk.fault = FLT_NONE;
    end
  end

endmodule
`default_nettype wire

// *** verification/tlbt_mem_model.sv ***
// Memory model holding descriptors and task-state records.
`timescale 1ns/1ns
`default_nettype none
module tlbt_mem_model (
  input  wire logic        clk,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  output logic             memAck,
  output logic      [31:0] memRdata
);
  logic   [31:0] mem [0:255];  // One flat space shared by every task.
  integer        seed = 24406;
  initial begin
    memAck = 1'b0;
    memRdata = 32'h0;
  end
  // Answer after a random stall; data is scrambled outside the ack cycle.
  always @(posedge clk) begin
    if (memReq && !memAck && ($random(seed) & 1)) begin
      memAck <= 1'b1;
      memRdata <= mem[memAddr[9:2]];
      if (memWe) mem[memAddr[9:2]] <= memWdata;
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
    end
  end
endmodule
`default_nettype wire

// *** verification/tlbt_task_link_tb.sv ***
// Self-checking bench for the task switch sequencer.
`timescale 1ns/1ns
`default_nettype none
module tlbt_task_link_tb;
  import tlbt_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [5:0]  regAddr = 6'h0;
  logic [31:0] regWdata = 32'h0, regRdata, memAddr, memWdata, memRdata;
  logic        memReq, memWe, memLock, memAck, switchActive, rdPend = 1'b0;
  logic [31:0] expQ [$];
  logic [31:0] pdbB;
  integer      seed = 24406, numErrors = 0, nCompared = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  tlbt_task_link dut_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .memReq(memReq), .memWe(memWe), .memLock(memLock), .memAddr(memAddr),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
    .switchActive(switchActive));
  tlbt_mem_model mem_u (.clk(clk), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck),
    .memRdata(memRdata));
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nCompared++;
    if (s !== e) begin
      numErrors++;
      $display("BAD %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    regAddr <= a; regWdata <= d; regWr <= 1'b1;
    @(posedge clk); regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    expQ.push_back(e); regAddr <= a; regRd <= 1'b1;
    @(posedge clk); regRd <= 1'b0;
    @(posedge clk);
  endtask
  // Starts a switch, waits for the sequencer to go idle, reads status.
  task automatic sw(input logic [1:0] k, input logic [15:0] s,
                    input logic [31:0] st);
    int n;
    n = 0;
    wr(REG_CMD_OFS, {s, 14'h0, k});
    while (switchActive === 1'b1 && n < 200) begin
      @(posedge clk); n++;
    end
    rd(REG_CMD_OFS, st);
  endtask
  // Read data is compared in the cycle after each read strobe.
  always @(posedge clk) begin
    if (rdPend) chk(regRdata, expQ.pop_front());
    // Descriptor words lie below 0x100; every write to them is locked.
    if (memReq && memWe && memAck && memAddr < 32'h100)
      chk({31'h0, memLock}, 32'h1);
    rdPend <= regRd;
    cyc++;
    if (cyc == 20000) begin
      numErrors++;
      print_verdict();
    end
  end
  // Main sequence: reset, set up two tasks, then switch between them.
  initial begin
    pdbB = $random(seed);
    foreach (mem_u.mem[i]) mem_u.mem[i] = 32'h0;  // Links start at 0.
    mem_u.mem[2] = 32'h0100_0067; mem_u.mem[3] = 32'h0000_8B00;
    mem_u.mem[4] = 32'h0200_0067; mem_u.mem[5] = 32'h0000_8900;
    mem_u.mem[73] = 32'h2; mem_u.mem[71] = 32'h1000;
    mem_u.mem[137] = 32'h2; mem_u.mem[135] = pdbB;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(REG_FLAGS_OFS, FLAGS_RST);
    rd(REG_CTRL0_OFS, CTRL0_RST);
    rd(6'h3C, 32'h0);
    wr(REG_TLIMIT_OFS, 32'hFF); wr(REG_TSEL_OFS, 32'h8);
    wr(REG_TRBASE_OFS, 32'h100);
    sw(KIND_CALL, 16'h10, 32'h20);
    rd(REG_FLAGS_OFS, 32'h4002);
    rd(REG_CTRL0_OFS, 32'h8);
    rd(REG_PDB_OFS, pdbB);
    rd(REG_TSEL_OFS, 32'h10);
    chk(mem_u.mem[128], 32'h8);
    chk(mem_u.mem[64], 32'h0);
    chk(mem_u.mem[5], 32'h8B00);
    chk(mem_u.mem[3], 32'h8B00);
    chk(mem_u.mem[73], 32'h2);
    $display("call test done");
    sw(KIND_CALL, 16'h08, 32'h22);
    rd(REG_ERR_OFS, 32'h8);
    $display("busy target test done");
    wr(REG_CTRL0_OFS, 32'h0);
    sw(KIND_INTERRUPT_RETURN, 16'h0, 32'h20);
    rd(REG_TSEL_OFS, 32'h8);
    rd(REG_FLAGS_OFS, 32'h2);
    rd(REG_CTRL0_OFS, 32'h8);
    rd(REG_PDB_OFS, 32'h1000);
    chk(mem_u.mem[5], 32'h8900);
    chk(mem_u.mem[3], 32'h8B00);
    chk(mem_u.mem[137], 32'h2);
    sw(KIND_INTERRUPT_RETURN, 16'h0, 32'h60);
    $display("return test done");
    wr(REG_CTRL0_OFS, 32'h0);
    sw(KIND_JUMP, 16'h10, 32'h20);
    rd(REG_FLAGS_OFS, 32'h2);
    rd(REG_CTRL0_OFS, 32'h8);
    chk(mem_u.mem[128], 32'h8);
    chk(mem_u.mem[3], 32'h8900);
    chk(mem_u.mem[5], 32'h8B00);
    $display("jump test done");
    // Software sets nesting; the linked task is not busy, so return fails.
    wr(REG_FLAGS_OFS, 32'h4002);
    rd(REG_FLAGS_OFS, 32'h4002);
    sw(KIND_INTERRUPT_RETURN, 16'h0, 32'h23);
    rd(REG_ERR_OFS, 32'h8);
    // Software unlinks the nested record; a spurious return then fails.
    mem_u.mem[128] = 32'h0;
    sw(KIND_INTERRUPT_RETURN, 16'h0, 32'h23);
    rd(REG_ERR_OFS, 32'h0);
    $display("unlink test done");
    sw(KIND_INTR, 16'h08, 32'h20);
    rd(REG_FLAGS_OFS, 32'h4002);
    rd(REG_PDB_OFS, 32'h1000);
    chk(mem_u.mem[64], 32'h10);
    chk(mem_u.mem[3], 32'h8B00);
    chk(mem_u.mem[5], 32'h8B00);
    chk(mem_u.mem[137], 32'h4002);
    $display("interrupt test done");
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule
`default_nettype wire
